//--- src/ebus_pkg.sv
// External memory/IO bus interface: shared constants, types and pin groups.
// Assumes a single 125 MHz machine-cycle clock and a synchronous reset.
package ebus_pkg;

  localparam int ADDR_W         = 16;
  localparam int DATA_W         = 16;
  localparam int WS_W           = 3;
  localparam int WS_MAX         = 7;
  localparam int GLOBAL_ADDR_W  = 15;
  localparam int SYNC_STAGES    = 2;
  localparam int SYNC_W         = DATA_W + 2;
  localparam int SYNC_READY_BIT = DATA_W;
  localparam int SYNC_FLOAT_BIT = DATA_W + 1;

  localparam logic [ADDR_W-1:0] ADDR_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET   = 16'h0000;
  localparam logic [ADDR_W-1:0] GLOBAL_BASE  = 16'h8000;
  localparam logic [WS_W-1:0]   WS_RESET     = 3'h0;

  // Address spaces: 64K program, 64K data, 64K I/O, 32K global data
  typedef enum logic [1:0] {
    SP_PROG   = 2'h0,
    SP_DATA   = 2'h1,
    SP_IO     = 2'h2,
    SP_GLOBAL = 2'h3
  } ebus_space_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ACCESS = 4'h2,
    ST_WAIT   = 4'h4,
    ST_END    = 4'h8
  } ebus_state_t;

  typedef struct packed {
    ebus_space_t           space;
    logic                  write;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [WS_W-1:0]       wait_states;
  } ebus_req_t;

  // Space selects, low active; at most one is low at any time
  typedef struct packed {
    logic prog_space_sel_n;
    logic data_space_sel_n;
    logic io_space_sel_n;
  } ebus_sel_t;

  localparam ebus_sel_t SEL_IDLE = 3'h7;
  localparam ebus_req_t REQ_RESET = '{space: SP_PROG, write: 1'b0, addr: ADDR_RESET,
                                      wdata: DATA_RESET, wait_states: WS_RESET};

endpackage

//--- src/ebus_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is a level that the far side holds for several cycles.
`timescale 1ns/100ps
module ebus_sync
  import ebus_pkg::*;
#(
  parameter int          WIDTH = SYNC_W,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  if (WIDTH < 1) begin : g_chk
    $error("ebus_sync: WIDTH must be at least 1");
  end

  always_comb begin
    next_meta = sys_rst_in ? RESET_VAL : async_in;
    next_sync = sys_rst_in ? RESET_VAL : meta;
  end

  always_ff @(posedge ref_clk_in) begin
    meta     <= next_meta;
    sync_out <= next_sync;
  end

endmodule

//--- src/ebus_wait_cnt.sv
// Programmable wait-state down counter.
// Loaded at the first cycle of an external access; expired once it reaches zero.
// Runs one cycle beyond the programmed count. The two-flop ready and data pins
// then show values from inside the bus cycle, even with zero wait states.
`timescale 1ns/100ps
module ebus_wait_cnt
  import ebus_pkg::*;
#(
  parameter int CNT_W = WS_W
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] count_in,
  output logic                  expired_out
);

  logic [CNT_W:0]   cnt;
  logic [CNT_W:0]   next_cnt;

  if (CNT_W < 1) begin : g_chk
    $error("ebus_wait_cnt: CNT_W must be at least 1");
  end

  always_comb begin
    if (sys_rst_in) begin
      next_cnt = '0;
    end else if (load_in) begin
      next_cnt = {1'b0, count_in} + (CNT_W+1)'(1);
    end else if (cnt != '0) begin
      next_cnt = cnt - (CNT_W+1)'(1);
    end else begin
      next_cnt = cnt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    cnt <= next_cnt;
  end

  assign expired_out = (cnt == '0) && !load_in;

endmodule

//--- src/ebus_if_ctrl.sv
// External memory/IO bus controller: turns core access requests into bus cycles.
// Assumes the core holds a request until accepted; pins are resolved by the pad ring.
`timescale 1ns/100ps
module ebus_if_ctrl
  import ebus_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              req_valid_in,
  input  wire ebus_req_t         req_in,
  output logic                   req_ready_out,
  output logic                   done_out,
  output logic [DATA_W-1:0]      rdata_out,
  input  wire logic              read_pin_select_in,
  input  wire logic              float_n_in,
  input  wire logic              ready_in,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   addr_oe_out,
  output ebus_sel_t              sel_out,
  output logic                   rw_out,
  output logic                   rd_pin_out,
  output logic                   we_n_out,
  output logic                   bus_cycle_strobe_n_out,
  output logic                   ctrl_oe_out
);

  localparam logic [SYNC_W-1:0] SYNC_RESET = {2'h3, DATA_RESET};

  logic [SYNC_W-1:0] pins_sync;
  logic              ready_q;
  logic              float_low;
  logic              ws_expired;
  logic              ws_load;

  ebus_state_t       state;
  ebus_state_t       next_state;
  ebus_req_t         req_q;
  ebus_req_t         next_req_q;

  logic              next_req_ready;
  logic              next_done;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] next_data;
  logic              next_data_oe;
  logic [ADDR_W-1:0] next_addr;
  logic              next_addr_oe;
  ebus_sel_t         next_sel;
  logic              next_rw;
  logic              next_rd_pin;
  logic              next_we_n;
  logic              next_strobe_n;
  logic              next_ctrl_oe;
  logic              cyc_active;

  // Decodes which select a space drives; global data shares the data select
  function automatic ebus_sel_t space_sel(input ebus_space_t sp);
    ebus_sel_t s;
    s = SEL_IDLE;
    case (sp)
      SP_PROG:   s.prog_space_sel_n = 1'b0;
      SP_DATA:   s.data_space_sel_n = 1'b0;
      SP_GLOBAL: s.data_space_sel_n = 1'b0;
      SP_IO:     s.io_space_sel_n   = 1'b0;
      default:   s = SEL_IDLE;
    endcase
    return s;
  endfunction

  // Global space is 32K words, folded into the upper half of the address range
  function automatic logic [ADDR_W-1:0] space_addr(input ebus_space_t sp, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    if (sp == SP_GLOBAL) begin
      r = GLOBAL_BASE | {{(ADDR_W-GLOBAL_ADDR_W){1'b0}}, a[GLOBAL_ADDR_W-1:0]};
    end
    return r;
  endfunction

  // Ready, float and read data are pins from outside the clock domain
  ebus_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({float_n_in, ready_in, data_in}),
    .sync_out   (pins_sync)
  );

  assign ready_q   = pins_sync[SYNC_READY_BIT];
  assign float_low = !pins_sync[SYNC_FLOAT_BIT];
  assign ws_load   = (state == ST_ACCESS);

  ebus_wait_cnt #(
    .CNT_W (WS_W)
  ) u_wait (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .load_in     (ws_load),
    .count_in    (req_q.wait_states),
    .expired_out (ws_expired)
  );

  // Cycle sequencing
  always_comb begin
    next_state = state;
    next_req_q = req_q;
    case (state)
      ST_IDLE: begin
        if (req_valid_in && req_ready_out) begin
          next_state = ST_ACCESS;
          next_req_q = req_in;
        end
      end
      ST_ACCESS: begin
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (ws_expired && ready_q) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (sys_rst_in) begin
      next_state = ST_IDLE;
      next_req_q = REQ_RESET;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    state <= next_state;
    req_q <= next_req_q;
  end

  // Pin values follow the next state so that every output is a flip-flop
  always_comb begin
    cyc_active     = (next_state == ST_ACCESS) || (next_state == ST_WAIT);
    next_req_ready = (next_state == ST_IDLE);
    next_done      = (next_state == ST_END);
    next_rdata     = rdata_out;
    if (state == ST_WAIT && next_state == ST_END && !req_q.write) begin
      next_rdata = pins_sync[DATA_W-1:0];
    end
    next_addr      = addr_out;
    if (next_state == ST_ACCESS) begin
      next_addr = space_addr(next_req_q.space, next_req_q.addr);
    end
    next_data      = cyc_active ? next_req_q.wdata : data_out;
    next_sel       = cyc_active ? space_sel(next_req_q.space) : SEL_IDLE;
    next_strobe_n  = !cyc_active;
    next_rw        = !(cyc_active && next_req_q.write);
    next_we_n      = !(cyc_active && next_req_q.write);
    // Inverted direction gives a glueless read strobe for zero-wait memories
    next_rd_pin    = read_pin_select_in ? !next_rw : !(cyc_active && !next_req_q.write);
    // Data is driven only while the write strobe is low
    next_data_oe   = cyc_active && next_req_q.write && !float_low;
    next_addr_oe   = !float_low;
    next_ctrl_oe   = !float_low;
    if (sys_rst_in) begin
      next_req_ready = 1'b0;
      next_done      = 1'b0;
      next_rdata     = DATA_RESET;
      next_addr      = ADDR_RESET;
      next_data      = DATA_RESET;
      next_sel       = SEL_IDLE;
      next_strobe_n  = 1'b1;
      next_rw        = 1'b1;
      next_we_n      = 1'b1;
      next_rd_pin    = 1'b1;
      next_data_oe   = 1'b0;
      next_addr_oe   = 1'b0;
      next_ctrl_oe   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    req_ready_out          <= next_req_ready;
    done_out               <= next_done;
    rdata_out              <= next_rdata;
    addr_out               <= next_addr;
    data_out               <= next_data;
    sel_out                <= next_sel;
    bus_cycle_strobe_n_out <= next_strobe_n;
    rw_out                 <= next_rw;
    we_n_out               <= next_we_n;
    rd_pin_out             <= next_rd_pin;
    data_oe_out            <= next_data_oe;
    addr_oe_out            <= next_addr_oe;
    ctrl_oe_out            <= next_ctrl_oe;
  end

  // Helper: length of the current strobe-low stretch, saturating at 31
  logic [4:0] low_cnt;
  logic [4:0] next_low_cnt;

  always_comb begin
    next_low_cnt = bus_cycle_strobe_n_out ? 5'h00 : ((low_cnt == 5'h1f) ? low_cnt : low_cnt + 5'h01);
    if (sys_rst_in) begin
      next_low_cnt = 5'h00;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    low_cnt <= next_low_cnt;
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_wait_open;
    state == ST_WAIT && ws_expired && !ready_q;
  endsequence

  sequence s_float_seen;
    float_low ##1 float_low;
  endsequence

  property p_data_float;
    data_oe_out |-> !we_n_out && !rw_out && ctrl_oe_out;
  endproperty
  a_data_float: assert property (p_data_float) else $error("data bus driven outside a write");

  property p_all_float;
    s_float_seen |-> !data_oe_out && !addr_oe_out && !ctrl_oe_out;
  endproperty
  a_all_float: assert property (p_all_float) else $error("bus not floated while float input low");

  property p_prog_sel;
    !sel_out.prog_space_sel_n |-> !bus_cycle_strobe_n_out && req_q.space == SP_PROG;
  endproperty
  a_prog_sel: assert property (p_prog_sel) else $error("program select outside program cycle");

  property p_data_sel;
    !sel_out.data_space_sel_n |-> !bus_cycle_strobe_n_out && (req_q.space inside {SP_DATA, SP_GLOBAL});
  endproperty
  a_data_sel: assert property (p_data_sel) else $error("data select outside data cycle");

  property p_io_sel;
    !sel_out.io_space_sel_n |-> !bus_cycle_strobe_n_out && req_q.space == SP_IO;
  endproperty
  a_io_sel: assert property (p_io_sel) else $error("io select outside io cycle");

  property p_one_sel;
    $countones(~sel_out) <= 1 && (bus_cycle_strobe_n_out == (sel_out == SEL_IDLE));
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("select count wrong");

  property p_stable;
    !bus_cycle_strobe_n_out && !$past(bus_cycle_strobe_n_out) |-> $stable(addr_out) && $stable(rw_out) && $stable(sel_out);
  endproperty
  a_stable: assert property (p_stable) else $error("address or control changed mid cycle");

  property p_ready_extend;
    s_wait_open |=> state == ST_WAIT && !bus_cycle_strobe_n_out;
  endproperty
  a_ready_extend: assert property (p_ready_extend) else $error("cycle ended while ready low");

  property p_wait_len;
    $rose(bus_cycle_strobe_n_out) |-> low_cnt >= 5'({2'h0, req_q.wait_states}) + 5'h03;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("cycle shorter than wait states");

  property p_rd_pin;
    state == ST_WAIT && !req_q.write |-> !rd_pin_out ##1 (state != ST_END || rd_pin_out == !read_pin_select_in);
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("read pin wrong during read");

  property p_strobe_idle;
    state == ST_IDLE |-> bus_cycle_strobe_n_out && rw_out && we_n_out;
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobe or write low while idle");

endmodule

//--- bench/ebus_mem_model.sv
// External memory model: program, data and I/O word arrays behind the bus pins.
// Assumes pins as seen on the wire; floated controls read as pulled high.
`timescale 1ns/100ps
module ebus_mem_model
  import ebus_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire ebus_sel_t         sel_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              rw_in,
  input  wire logic              we_n_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [3:0]        stall_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   ready_out
);
  logic [DATA_W-1:0] mem [3][2**ADDR_W];
  logic [DATA_W-1:0] last;
  logic [3:0]        cnt;
  logic              act;
  int                sp;

  initial last = 16'h0000;
  initial cnt = 4'h0;
  assign act = (sel_in != SEL_IDLE);
  assign sp = !sel_in.prog_space_sel_n ? 0 : (!sel_in.data_space_sel_n ? 1 : 2);
  // Released bus shows the inverse of the last word so stale data cannot pass
  assign data_out = (act && rw_in) ? mem[sp][addr_in] : ~last;
  // Ready held low for stall_in active cycles and while idle with stall_in nonzero, otherwise high
  assign ready_out = (cnt == 4'h0);

  always @(posedge ref_clk_in) begin
    if (act && rw_in) begin
      last <= mem[sp][addr_in];
    end
    if (act && !we_n_in) begin
      mem[sp][addr_in] <= wdata_in;
    end
    if (!act) begin
      cnt <= stall_in;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

//--- bench/external_memory_io_bus_tb.sv
// Self-checking bench for the external bus controller with a memory model.
// Assumes the controller timing: 4+W cycles per access plus ready stalls.
`timescale 1ns/100ps
module external_memory_io_bus_tb;
  import ebus_pkg::*;
  logic              ref_clk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              req_valid_in = 1'b0;
  ebus_req_t         req_in = REQ_RESET;
  logic              rps = 1'b0;
  logic              float_n_in = 1'b1;
  logic [3:0]        stall = 4'h0;
  logic              req_ready_out, done_out, data_oe_out, addr_oe_out, rw_out;
  logic              rd_pin_out, we_n_out, bus_cycle_strobe_n_n, ctrl_oe_out, ready_w;
  logic [DATA_W-1:0] rdata_out, data_out, mem_data, data_w;
  logic [ADDR_W-1:0] addr_out;
  ebus_sel_t         sel_out, sel_w;
  int                bad_count = 0;
  int                checked = 0;
  int                cycles = 0;

  always #4 ref_clk_in = ~ref_clk_in;
  assign sel_w = ctrl_oe_out ? sel_out : SEL_IDLE;
  assign data_w = data_oe_out ? data_out : mem_data;

  ebus_if_ctrl dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .done_out(done_out), .rdata_out(rdata_out),
    .read_pin_select_in(rps), .float_n_in(float_n_in), .ready_in(ready_w), .data_in(data_w),
    .data_out(data_out), .data_oe_out(data_oe_out), .addr_out(addr_out), .addr_oe_out(addr_oe_out),
    .sel_out(sel_out), .rw_out(rw_out), .rd_pin_out(rd_pin_out), .we_n_out(we_n_out),
    .bus_cycle_strobe_n_out(bus_cycle_strobe_n_n), .ctrl_oe_out(ctrl_oe_out));

  ebus_mem_model mem (.ref_clk_in(ref_clk_in), .sel_in(sel_w), .addr_in(addr_out),
    .rw_in(ctrl_oe_out ? rw_out : 1'b1), .we_n_in(ctrl_oe_out ? we_n_out : 1'b1), .wdata_in(data_w),
    .stall_in(stall), .data_out(mem_data), .ready_out(ready_w));

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One bus access; entered just after a rising edge, returns just after one
  task automatic access(input ebus_space_t sp, input logic wr, input logic [15:0] a,
                        input logic [15:0] d, input logic [2:0] ws, output int lat);
    ebus_sel_t   es;
    logic [15:0] ea;
    logic        fl;
    ea = (sp == SP_GLOBAL) ? (GLOBAL_BASE | {1'b0, a[14:0]}) : a;
    es = SEL_IDLE;
    fl = float_n_in;
    case (sp)
      SP_PROG: es.prog_space_sel_n = 1'b0;
      SP_IO: es.io_space_sel_n = 1'b0;
      default: es.data_space_sel_n = 1'b0;
    endcase
    req_in = '{space: sp, write: wr, addr: a, wdata: d, wait_states: ws};
    req_valid_in = 1'b1;
    do @(negedge ref_clk_in); while (req_ready_out !== 1'b1);
    @(posedge ref_clk_in);
    #1 req_valid_in = 1'b0;
    lat = 0;
    do begin
      @(negedge ref_clk_in);
      lat++;
      if (done_out !== 1'b1) begin
        chk_word({13'h0, sel_out}, {13'h0, es}, "space select");
        chk_word(addr_out, ea, "address");
        chk_bit(bus_cycle_strobe_n_n, 1'b0, "strobe");
        chk_bit(rw_out, ~wr, "direction");
        chk_bit(we_n_out, ~wr, "write strobe");
        chk_bit(rd_pin_out, wr, "read pin");
        chk_bit(data_oe_out, wr & fl, "data enable");
        chk_bit(addr_oe_out & ctrl_oe_out, fl, "pin enables");
        if (wr) chk_word(data_out, d, "write data");
      end
    end while (done_out !== 1'b1 && lat < 40);
    chk_bit(bus_cycle_strobe_n_n, 1'b1, "strobe at end");
    chk_bit(rd_pin_out, ~rps, "read pin idle");
    if (!wr) chk_word(rdata_out, d, "read data");
    @(posedge ref_clk_in);
    #1;
  endtask

  // Idle bus: no select, read direction, data released
  always @(negedge ref_clk_in) begin
    if (!sys_rst_in && bus_cycle_strobe_n_n === 1'b1) begin
      chk_word({13'h0, sel_out}, {13'h0, SEL_IDLE}, "idle selects");
      chk_bit(rw_out, 1'b1, "idle direction");
      chk_bit(data_oe_out, 1'b0, "idle data enable");
    end
  end

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("BAD %0t run did not finish", $time);
      close_out();
    end
  end

  task automatic t_reset();
    chk_bit(data_oe_out | addr_oe_out | ctrl_oe_out, 1'b0, "enables in reset");
    chk_bit(bus_cycle_strobe_n_n & we_n_out & rw_out & rd_pin_out, 1'b1, "controls in reset");
  endtask

  // Each space written then read back; wait states 0..7 with exact latency
  task automatic t_spaces();
    logic [15:0] ad [4] = '{16'hffff, 16'h0000, 16'h8001, 16'h7fff};
    logic [15:0] dv [4] = '{16'h8001, 16'h7ffe, 16'hc3a5, 16'h5a3c};
    int          lat;
    for (int i = 0; i < 4; i++) begin
      access(ebus_space_t'(i), 1'b1, ad[i], dv[i], 3'(i), lat);
      chk_word(16'(lat), 16'(4 + i), "write latency");
    end
    for (int i = 0; i < 4; i++) begin
      access(ebus_space_t'(i), 1'b0, ad[i], dv[i], 3'(7 - i), lat);
      chk_word(16'(lat), 16'(11 - i), "read latency");
    end
  endtask

  // Ready held low stretches the cycle; high again gives the bare count
  task automatic t_ready();
    int lat;
    stall = 4'h6;
    access(SP_DATA, 1'b0, 16'h0000, 16'h7ffe, 3'h1, lat);
    // Six low cycles from the first strobe cycle, then two cycles of pin delay
    chk_word(16'(lat), 16'h000a, "ready stretch");
    stall = 4'h0;
    access(SP_DATA, 1'b0, 16'h0000, 16'h7ffe, 3'h1, lat);
    chk_word(16'(lat), 16'h5, "ready high");
  endtask

  task automatic t_mode();
    int lat;
    rps = 1'b1;
    access(SP_IO, 1'b1, 16'h0042, 16'h1248, 3'h0, lat);
    chk_word(16'(lat), 16'h4, "mode write latency");
    access(SP_IO, 1'b0, 16'h0042, 16'h1248, 3'h0, lat);
    chk_word(16'(lat), 16'h4, "mode read latency");
    rps = 1'b0;
  endtask

  // Float low releases every pin but the access still completes
  task automatic t_float();
    int lat;
    float_n_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    #1;
    access(SP_PROG, 1'b1, 16'h0100, 16'ha55a, 3'h2, lat);
    chk_word(16'(lat), 16'h6, "floated latency");
    float_n_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    t_reset();
    @(posedge ref_clk_in);
    #1 sys_rst_in = 1'b0;
    t_spaces();
    t_ready();
    t_mode();
    t_float();
    close_out();
  end
endmodule
